/* pkg/usart_params.svh */
// Register offsets, field positions, reset values and counts of the USART
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH
`define OFS_DATA    8'h00      // Data buffer port
`define OFS_SCRA    8'h04      // Status/control register A
`define OFS_SCRB    8'h08      // Status/control register B
`define OFS_CFG     8'h0C      // Frame format
`define OFS_BAUD    8'h10      // Oversample divisor
`define A_RDY       7
`define A_TDN       6
`define A_TBE       5
`define A_FRM       4
`define A_OVR       3
`define A_PAR       2
`define B_TDNIE     6
`define B_TBEIE     5
`define B_RXON      4
`define B_TXON      3
`define B_RX9       1
`define B_TX9       0
`define CS_NINE     3'h7       // Nine-bit characters
`define OS_LAST     4'hF       // Sixteen oversample ticks per bit
`define OS_MID      4'h7       // Middle of the start bit
`define BAUD_RST    12'h019    // Plain default divisor
`define CFG_RST     7'h03      // Async, one stop, no parity, 8 bits
`define FIFO_FULL   2'h2       // Two-character receive buffer
`endif

/* pkg/usart_pkg.sv */
// Types shared by the USART datapath
package usart_pkg;
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } rx_state_e;
  // One receive buffer slot: data with its status
  typedef struct packed {
    logic       ninth;
    logic       frm;
    logic       ovr;
    logic       par;
    logic [7:0] data;
  } rx_entry_s;
  // Frame format register
  typedef struct packed {
    logic       sync_mode;
    logic       two_stop;
    logic [1:0] parity_mode;
    logic [2:0] character_size_field;
  } frame_cfg_s;
endpackage : usart_pkg

/* core/usart_core.sv */
// USART transmit/receive datapath with AHB-Lite register slave
// What this block and its software must do
// RULE1 - Buffer-empty flag high while transmit buffer empty
// RULE2 - Software writes zero to buffer-empty position
// RULE3 - Buffer-empty request held while flag set
// RULE4 - Data port write fills buffer, clears flag
// RULE5 - Done flag set when frame out, buffer empty
// RULE6 - Done flag cleared when taken or one written
// RULE7 - Done request raised when done flag sets
// RULE8 - Parity bit sent after last data bit
// RULE9 - Disable waits until shifter and buffer drain
// RULE10 - Receiver enable takes over serial input pin
// RULE11 - Synchronous mode samples on external transfer clock
// RULE12 - Reception starts on valid start bit only
// RULE13 - Second stop bit is ignored
// RULE14 - First stop bit moves frame into buffer
// RULE15 - Short characters read with upper zeros
// RULE16 - Software reads ninth bit before low byte
// RULE17 - Ninth bit and errors stored per frame
// RULE18 - Software reads status before data port
// RULE19 - Receive-complete flag shows unread data
// RULE20 - Receiver disable flushes buffer at once
// RULE21 - Framing error reflects first stop bit
// RULE22 - Overrun when buffer full and shifter waiting
// RULE23 - Software sets ninth bit before low byte
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`include "usart_params.svh"
`timescale 1ns/1ps
`default_nettype none
module usart_core (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxd_pin,
  input  wire logic        sync_transfer_clock_pin,
  input  wire logic        tx_done_irq_taken,
  output logic             txd_out,
  output logic             txd_oe_b,
  output logic             rx_pin_owned,
  output logic             buffer_empty_irq,
  output logic             tx_done_irq
);
  import usart_pkg::*;

  // Data bits per character from the size field
  function automatic logic [3:0] frame_bits(input logic [2:0] cs);
    frame_bits = (cs == `CS_NINE) ? 4'h9 : 4'h5 + {2'h0, cs[1:0]};
  endfunction : frame_bits
  // Parity over masked data; odd parity inverts
  function automatic logic par_of(input logic [8:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of

  logic        ap_valid_ff;    // Data phase pending
  logic        ap_write_ff;    // Pending access is a write
  logic [7:0]  ap_addr_ff;     // Pending word address
  logic        hreadyout_ff;   // One wait state per access
  logic [31:0] hrdata_ff;      // Read data register
  frame_cfg_s  cfg_ff;         // Frame format
  logic [11:0] baud_ff;        // Oversample divisor
  logic        txon_ff;        // Transmitter on
  logic        rxon_ff;        // Receiver on
  logic        tbeie_ff;       // Buffer-empty request enable
  logic        tdnie_ff;       // Done request enable
  logic        tx9_ff;         // Transmit ninth bit
  logic        tdn_ff;         // Transmit done flag
  logic [8:0]  tx_buf_ff;      // Transmit buffer
  logic        tx_buf_v_ff;    // Buffer holds unsent character
  logic [8:0]  tx_sh_ff;       // Transmit shifter
  logic        tx_par_ff;      // Parity for current frame
  logic [3:0]  tx_cnt_ff;      // Data bits sent
  tx_state_e   tx_st_ff;       // Transmitter state
  logic [11:0] div_ff;         // Baud divider
  logic        os_tick_ff;     // 16x bit rate enable
  logic [3:0]  tx_os_ff;       // Oversample phase for transmit
  logic        rxd_m_ff;       // Input synchroniser stages
  logic        rxd_s_ff;
  logic        sck_m_ff;
  logic        sck_s_ff;
  logic        sck_d_ff;       // Delayed copy for edge detect
  rx_state_e   rx_st_ff;       // Receiver state
  logic [3:0]  rx_os_ff;       // Oversample phase for receive
  logic [3:0]  rx_cnt_ff;      // Data bits taken
  logic [8:0]  rx_sh_ff;       // Receive shifter
  logic        rx_par_ff;      // Received parity bit
  rx_entry_s   hold_ff;        // Frame waiting in the shifter
  logic        hold_v_ff;
  logic        ovr_pend_ff;    // Overrun seen, tag next frame
  rx_entry_s   mem [0:1];      // Two-character receive buffer
  logic        wptr_ff;
  logic        rptr_ff;
  logic [1:0]  fcnt_ff;
  logic        txd_ff;
  logic        txd_oe_b_ff;
  logic        rx_own_ff;
  logic        be_irq_ff;
  logic        td_irq_ff;

  // Combinational helpers
  logic [3:0]  nb;
  logic        par_en;
  logic        sck_rise;
  logic        tx_tick;
  logic        rx_samp;
  logic        wr_cyc;
  logic        rd_cyc;
  logic        wr_data;
  logic        rd_data;
  logic        tx_load;
  logic        tx_fin;
  logic        tdn_set;
  logic        start_det;
  logic        frame_done;
  logic        push;
  logic        pop;
  logic        rdy;
  logic        tbe;
  logic [8:0]  rx_val;
  rx_entry_s   head;
  rx_entry_s   new_ent;

  assign nb       = frame_bits(cfg_ff.character_size_field);
  assign par_en   = cfg_ff.parity_mode[1];
  assign sck_rise = sck_s_ff & ~sck_d_ff;
  assign wr_cyc   = ap_valid_ff & ap_write_ff;
  assign rd_cyc   = ap_valid_ff & ~ap_write_ff;
  assign wr_data  = wr_cyc & (ap_addr_ff == `OFS_DATA);
  assign rd_data  = rd_cyc & (ap_addr_ff == `OFS_DATA);
  assign tbe      = ~tx_buf_v_ff;                             // RULE1
  assign rdy      = (fcnt_ff != 2'h0);                        // RULE19
  assign head     = mem[rptr_ff];
  // Bit clock: transfer clock edge in sync mode, else divided tick
  assign tx_tick  = cfg_ff.sync_mode ? sck_rise :
                    (os_tick_ff && tx_os_ff == `OS_LAST);
  assign rx_samp  = cfg_ff.sync_mode ? sck_rise :             // RULE11
                    (os_tick_ff && rx_os_ff == `OS_LAST);
  assign tx_fin   = tx_tick && ((tx_st_ff == TX_STOP2) ||
                    (tx_st_ff == TX_STOP1 && !cfg_ff.two_stop));
  assign tx_load  = tx_buf_v_ff && (tx_fin ||
                    (tx_tick && tx_st_ff == TX_IDLE));
  assign tdn_set  = tx_fin && !tx_buf_v_ff;                   // RULE5
  assign start_det = rxon_ff && rx_st_ff == RX_IDLE && !rxd_s_ff &&
                     (!cfg_ff.sync_mode || sck_rise);         // RULE12
  assign frame_done = rxon_ff && rx_st_ff == RX_STOP && rx_samp;
  assign rx_val   = rx_sh_ff >> (4'h9 - nb);                  // RULE15
  assign push     = hold_v_ff && fcnt_ff != `FIFO_FULL;
  assign pop      = rd_data && rdy;
  always_comb begin
    new_ent.ninth = (nb == 4'h9) ? rx_val[8] : 1'b0;
    new_ent.data  = rx_val[7:0];
    new_ent.frm   = ~rxd_s_ff;                                // RULE21
    new_ent.ovr   = ovr_pend_ff;
    new_ent.par   = par_en &&
                    (par_of(rx_val, cfg_ff.parity_mode[0]) != rx_par_ff);
  end

  // Bus address phase; every access takes one wait state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ap_valid_ff  <= 1'b0;
      ap_write_ff  <= 1'b0;
      ap_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
    end else begin
      ap_valid_ff  <= hsel & hready & htrans[1];
      ap_write_ff  <= hwrite;
      ap_addr_ff   <= {haddr[7:2], 2'h0};
      hreadyout_ff <= ~(hsel & hready & htrans[1]);
    end
  end

  // Read data captured in the data phase, after any write before it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_cyc) begin
      case (ap_addr_ff)
        `OFS_DATA: hrdata_ff <= {24'h0, rdy ? head.data : 8'h00};
        `OFS_SCRA: hrdata_ff <= {24'h0, rdy, tdn_ff, tbe,
                                 rdy & head.frm, rdy & head.ovr,
                                 rdy & head.par, 2'h0};       // RULE17
        `OFS_SCRB: hrdata_ff <= {24'h0, 1'b0, tdnie_ff, tbeie_ff,
                                 rxon_ff, txon_ff, 1'b0,
                                 rdy & head.ninth, tx9_ff};
        `OFS_CFG:  hrdata_ff <= {25'h0, cfg_ff};
        `OFS_BAUD: hrdata_ff <= {20'h0, baud_ff};
        default:   hrdata_ff <= 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
  end

  // Control registers; of the flag bits in register A only the done flag takes a write, where a one clears it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff   <= `CFG_RST;
      baud_ff  <= `BAUD_RST;
      txon_ff  <= 1'b0;
      rxon_ff  <= 1'b0;
      tbeie_ff <= 1'b0;
      tdnie_ff <= 1'b0;
      tx9_ff   <= 1'b0;
    end else if (wr_cyc) begin
      case (ap_addr_ff)
        `OFS_SCRB: begin
          tdnie_ff <= hwdata[`B_TDNIE];
          tbeie_ff <= hwdata[`B_TBEIE];
          rxon_ff  <= hwdata[`B_RXON];
          txon_ff  <= hwdata[`B_TXON];
          tx9_ff   <= hwdata[`B_TX9];   // Taken at the next data write
        end
        `OFS_CFG:  cfg_ff  <= hwdata[6:0];
        `OFS_BAUD: baud_ff <= hwdata[11:0];
        default: ;                      // Other offsets ignore writes
      endcase
    end
  end

  // Oversample divider and input synchronisers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_ff     <= 12'h000;
      os_tick_ff <= 1'b0;
      tx_os_ff   <= 4'h0;
      rxd_m_ff   <= 1'b1;
      rxd_s_ff   <= 1'b1;
      sck_m_ff   <= 1'b0;
      sck_s_ff   <= 1'b0;
      sck_d_ff   <= 1'b0;
    end else begin
      os_tick_ff <= (div_ff == 12'h000);
      div_ff     <= (div_ff == 12'h000) ? baud_ff : div_ff - 12'h001;
      if (os_tick_ff) begin
        tx_os_ff <= tx_os_ff + 4'h1;
      end
      rxd_m_ff <= rxd_pin;
      rxd_s_ff <= rxd_m_ff;
      sck_m_ff <= sync_transfer_clock_pin;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
    end
  end

  // Transmit buffer; a write in the load cycle still lands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_ff   <= 9'h000;
      tx_buf_v_ff <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_buf_v_ff <= 1'b0;
      end
      if (wr_data && txon_ff) begin                           // RULE4
        tx_buf_ff   <= {tx9_ff, hwdata[7:0]} &
                       (9'h1FF >> (4'h9 - nb));
        tx_buf_v_ff <= 1'b1;                                  // RULE1
      end
    end
  end

  // Transmit shifter; a pending character follows the last stop bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_ff  <= TX_IDLE;
      tx_sh_ff  <= 9'h000;
      tx_par_ff <= 1'b0;
      tx_cnt_ff <= 4'h0;
    end else if (tx_load) begin
      tx_st_ff  <= TX_START;
      tx_sh_ff  <= tx_buf_ff;
      tx_par_ff <= par_of(tx_buf_ff, cfg_ff.parity_mode[0]);  // RULE8
      tx_cnt_ff <= 4'h0;
    end else if (tx_tick) begin
      case (tx_st_ff)
        TX_START: tx_st_ff <= TX_DATA;
        TX_DATA: begin
          tx_sh_ff  <= tx_sh_ff >> 1;
          tx_cnt_ff <= tx_cnt_ff + 4'h1;
          if (tx_cnt_ff == nb - 4'h1) begin
            tx_st_ff <= par_en ? TX_PARITY : TX_STOP1;        // RULE8
          end
        end
        TX_PARITY: tx_st_ff <= TX_STOP1;
        TX_STOP1:  tx_st_ff <= cfg_ff.two_stop ? TX_STOP2 : TX_IDLE;
        TX_STOP2:  tx_st_ff <= TX_IDLE;
        default:   tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Done flag: setting wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tdn_ff <= 1'b0;
    end else if (tdn_set) begin
      tdn_ff <= 1'b1;                                         // RULE5
    end else if (tx_done_irq_taken ||
                 (wr_cyc && ap_addr_ff == `OFS_SCRA &&
                  hwdata[`A_TDN])) begin
      tdn_ff <= 1'b0;                                         // RULE6
    end
  end

  // Pin and request outputs, all registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txd_ff      <= 1'b1;
      txd_oe_b_ff <= 1'b1;
      rx_own_ff   <= 1'b0;
      be_irq_ff   <= 1'b0;
      td_irq_ff   <= 1'b0;
    end else begin
      case (tx_st_ff)
        TX_START:  txd_ff <= 1'b0;
        TX_DATA:   txd_ff <= tx_sh_ff[0];
        TX_PARITY: txd_ff <= tx_par_ff;
        default:   txd_ff <= 1'b1;  // Idle and stop bits are high
      endcase
      // Pin stays ours while the transmitter is on, and after that until shifter and buffer are both empty
      txd_oe_b_ff <= ~(txon_ff || tx_buf_v_ff ||
                       tx_st_ff != TX_IDLE);                  // RULE9
      rx_own_ff   <= rxon_ff;                                 // RULE10
      be_irq_ff   <= tbeie_ff && tbe;                         // RULE3
      td_irq_ff   <= tdnie_ff && (tdn_ff || tdn_set) &&
                     !tx_done_irq_taken;                      // RULE7
    end
  end

  // Receiver sequencer; disable aborts a frame in flight
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_ff  <= RX_IDLE;
      rx_os_ff  <= 4'h0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff  <= 9'h000;
      rx_par_ff <= 1'b0;
    end else if (!rxon_ff) begin
      rx_st_ff <= RX_IDLE;
    end else begin
      if (os_tick_ff) begin
        rx_os_ff <= rx_os_ff + 4'h1;
      end
      case (rx_st_ff)
        RX_IDLE: if (start_det) begin                         // RULE12
          rx_st_ff  <= cfg_ff.sync_mode ? RX_DATA : RX_START;
          rx_os_ff  <= 4'h0;
          rx_cnt_ff <= 4'h0;
        end
        RX_START: if (os_tick_ff && rx_os_ff == `OS_MID) begin
          // Glitch shorter than half a bit is not a start
          rx_st_ff <= rxd_s_ff ? RX_IDLE : RX_DATA;
          rx_os_ff <= 4'h0;
        end
        RX_DATA: if (rx_samp) begin
          rx_sh_ff  <= {rxd_s_ff, rx_sh_ff[8:1]};
          rx_cnt_ff <= rx_cnt_ff + 4'h1;
          if (rx_cnt_ff == nb - 4'h1) begin
            rx_st_ff <= par_en ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (rx_samp) begin
          rx_par_ff <= rxd_s_ff;
          rx_st_ff  <= RX_STOP;
        end
        // Only the first stop bit is looked at
        RX_STOP: if (rx_samp) rx_st_ff <= RX_IDLE;            // RULE13
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Finished frame waits in the shifter, overrun tags the next one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_ff     <= '0;
      hold_v_ff   <= 1'b0;
      ovr_pend_ff <= 1'b0;
    end else if (!rxon_ff) begin
      hold_v_ff   <= 1'b0;                                    // RULE20
      ovr_pend_ff <= 1'b0;
    end else begin
      if (frame_done) begin
        hold_ff     <= new_ent;                               // RULE14
        hold_v_ff   <= 1'b1;
        ovr_pend_ff <= 1'b0;
      end else begin
        if (push) hold_v_ff <= 1'b0;
        if (start_det && fcnt_ff == `FIFO_FULL && hold_v_ff) begin
          ovr_pend_ff <= 1'b1;                                // RULE22
        end
      end
    end
  end

  // Receive buffer; a data port read advances it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      fcnt_ff <= 2'h0;
      mem[0]  <= '0;
      mem[1]  <= '0;
    end else if (!rxon_ff) begin
      wptr_ff <= 1'b0;                                        // RULE20
      rptr_ff <= 1'b0;
      fcnt_ff <= 2'h0;
    end else begin
      if (push) begin
        mem[wptr_ff] <= hold_ff;                              // RULE17
        wptr_ff      <= ~wptr_ff;
      end
      if (pop) rptr_ff <= ~rptr_ff;                           // RULE17
      fcnt_ff <= fcnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  assign hreadyout        = hreadyout_ff;
  assign hrdata           = hrdata_ff;
  assign hresp            = 1'b0;      // Always OKAY
  assign txd_out          = txd_ff;
  assign txd_oe_b         = txd_oe_b_ff;
  assign rx_pin_owned     = rx_own_ff;
  assign buffer_empty_irq = be_irq_ff;
  assign tx_done_irq      = td_irq_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_last_bit;
    tx_st_ff == TX_DATA && tx_tick && !tx_load && tx_cnt_ff == nb - 4'h1;
  endsequence
  sequence s_frame_in;
    frame_done ##1 hold_v_ff;
  endsequence
  a_wr_fills_buf: assert property (wr_data && txon_ff |=> !tbe) // RULE4
    else $error("data write did not clear buffer empty");
  a_be_req_level: assert property (tbeie_ff && tbe |=> buffer_empty_irq)
    else $error("buffer empty request missing"); // RULE3
  a_done_flag_set: assert property (tdn_set |=> tdn_ff)
    else $error("done flag not set after frame"); // RULE5
  a_done_w1_clear: assert property (wr_cyc && ap_addr_ff == `OFS_SCRA &&
      hwdata[`A_TDN] && !tdn_set |=> !tdn_ff)
    else $error("write one did not clear done flag"); // RULE6
  a_done_req_rise: assert property ($rose(tdn_ff) &&
      $past(tdnie_ff && !tx_done_irq_taken) |-> tx_done_irq)
    else $error("done request late"); // RULE7
  a_parity_slot: assert property (s_last_bit |=> (tx_st_ff == TX_PARITY)
      == par_en) else $error("parity slot wrong"); // RULE8
  a_tx_pin_held: assert property (tx_buf_v_ff ##1 1 |-> !txd_oe_b)
    else $error("pin released with pending data"); // RULE9
  a_rx_pin_take: assert property (rxon_ff |=> rx_pin_owned) // RULE10
    else $error("receive pin not taken");
  a_rx_flush: assert property (!rxon_ff |=> !rdy ##1 !rdy) // RULE20
    else $error("buffer not flushed on disable");
  a_frame_capture: assert property (s_frame_in |-> hold_ff.frm ==
      $past(!rxd_s_ff)) else $error("framing flag wrong"); // RULE21
  a_overrun_mark: assert property (start_det && fcnt_ff == `FIFO_FULL &&
      hold_v_ff && !frame_done |=> ovr_pend_ff)
    else $error("overrun not flagged"); // RULE22
endmodule : usart_core
`default_nettype wire

/* verif/remote_line_model.sv */
// Remote serial peer: drives the receive line, captures sent frames
`timescale 1ns/1ps
`default_nettype none
module remote_line_model (
  input  wire logic clk_sys,  // Bench clock
  input  wire logic txd,      // Line from the block's transmitter
  output var  logic rxd,      // Line into the block's receiver
  output var  logic sclk      // Transfer clock, still between frames
);
  localparam int BITCLK = 16; // Clocks per bit with divisor zero
  initial rxd = 1'b1;         // Idle line is high
  initial sclk = 1'b0;
  // Synchronous frame: bit set in low phase, taken on rising edge
  task automatic sync_send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    rxd <= 1'b1;
  endtask : sync_send
  // Start low, data LSB first, stop, then idle long enough to resync
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    rxd <= 1'b0;
    repeat (BITCLK) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (BITCLK) @(posedge clk_sys);
    end
    rxd <= stop;
    repeat (BITCLK) @(posedge clk_sys);
    rxd <= 1'b1;
    repeat (2 * BITCLK) @(posedge clk_sys);
  endtask : send
  // Find the start edge, then sample each bit near its middle
  task automatic grab(input int n, input logic pen, output logic [8:0] d,
                      output logic par, output logic stop);
    int guard;
    guard = 0;
    d = '0;
    par = 1'b0;
    while (txd !== 1'b0 && guard < 4000) begin
      @(posedge clk_sys);
      guard++;
    end
    repeat (BITCLK / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      repeat (BITCLK) @(posedge clk_sys);
      d[i] = txd;
    end
    if (pen) begin
      repeat (BITCLK) @(posedge clk_sys);
      par = txd;
    end
    repeat (BITCLK) @(posedge clk_sys);
    stop = txd;
  endtask : grab
endmodule : remote_line_model
`default_nettype wire

/* verif/usart_tx_rx_buffer_flags_tb_top.sv */
// Self-checking bench for the USART datapath
`include "usart_params.svh"
`timescale 1ns/1ps
`default_nettype none
module usart_tx_rx_buffer_flags_tb_top;
  logic        clk_sys, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sync_transfer_clock_pin, tx_done_irq_taken, txd_out, rxd;
  logic        txd_oe_b, rx_pin_owned, buffer_empty_irq, tx_done_irq;
  logic [8:0]  got;          // Captured frame data
  logic        gpar, gstop;  // Captured parity and stop bits
  int          bad_count, total_checks, cycles;
  // Single slave: its ready is the bus ready
  usart_core u_usart_core (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxd_pin(rxd),
    .sync_transfer_clock_pin(sync_transfer_clock_pin),
    .tx_done_irq_taken(tx_done_irq_taken), .txd_out(txd_out),
    .txd_oe_b(txd_oe_b), .rx_pin_owned(rx_pin_owned),
    .buffer_empty_irq(buffer_empty_irq), .tx_done_irq(tx_done_irq));
  remote_line_model u_remote_line_model (.clk_sys(clk_sys), .txd(txd_out),
    .rxd(rxd), .sclk(sync_transfer_clock_pin));
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard: far above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One AHB-Lite single word transfer, waits on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask : rchk
  // Poll a flag with a bounded number of reads
  task automatic wait_set(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    rd = '0;
    while ((rd & m) == 0 && n < 600) begin
      bus(1'b0, a, 32'h0, rd);
      n++;
    end
    chk(rd & m, m);
  endtask : wait_set
  task automatic t_tx;
    wr(`OFS_SCRB, 32'h68);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, buffer_empty_irq}, 32'h1);
    fork
      wr(`OFS_DATA, 32'hA5);
      u_remote_line_model.grab(8, 1'b0, got, gpar, gstop);
    join
    chk({23'h0, got}, 32'hA5);
    wait_set(`OFS_SCRA, 32'h40);
    chk({31'h0, tx_done_irq}, 32'h1);
    rchk(`OFS_SCRA, 32'h60, 32'h60);
    tx_done_irq_taken <= 1'b1;
    @(posedge clk_sys);
    tx_done_irq_taken <= 1'b0;
    @(posedge clk_sys);
    rchk(`OFS_SCRA, 32'h40, 32'h0);
    wr(`OFS_CFG, 32'h1F);
    wr(`OFS_SCRB, 32'h09);
    fork
      wr(`OFS_DATA, 32'h5A);
      u_remote_line_model.grab(9, 1'b1, got, gpar, gstop);
    join
    chk({22'h0, gpar, got}, 32'h15A);
    wait_set(`OFS_SCRA, 32'h40);
    wr(`OFS_SCRA, 32'h40);
    $display("test tx done");
  endtask : t_tx
  // Even parity frame, transmitter switched off right after the data write
  task automatic t_par;
    wr(`OFS_CFG, 32'h33);
    fork
      begin
        wr(`OFS_DATA, 32'h07);
        wr(`OFS_SCRB, 32'h00);
        chk({31'h0, txd_oe_b}, 32'h0);
      end
      u_remote_line_model.grab(8, 1'b1, got, gpar, gstop);
    join
    chk({22'h0, gpar, got}, 32'h207);
    wait_set(`OFS_SCRA, 32'h40);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, txd_oe_b}, 32'h1);
    wr(`OFS_SCRA, 32'h00);
    rchk(`OFS_SCRA, 32'h40, 32'h40);
    wr(`OFS_SCRA, 32'h40);
    rchk(`OFS_SCRA, 32'h40, 32'h0);
    $display("test parity done");
  endtask : t_par
  task automatic t_rx;
    wr(`OFS_CFG, 32'h23);
    wr(`OFS_SCRB, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, rx_pin_owned}, 32'h1);
    u_remote_line_model.send(9'h03C, 8, 1'b1);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_SCRA, 32'h1C, 32'h0);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h3C);
    rchk(`OFS_SCRA, 32'h80, 32'h0);
    u_remote_line_model.send(9'h055, 8, 1'b0);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_SCRA, 32'h10, 32'h10);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h55);
    wr(`OFS_CFG, 32'h00);
    u_remote_line_model.send(9'h0FF, 5, 1'b1);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h1F);
    wr(`OFS_CFG, 32'h07);
    u_remote_line_model.send(9'h1AB, 9, 1'b1);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_SCRB, 32'h02, 32'h02);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'hAB);
    wr(`OFS_CFG, 32'h43);
    u_remote_line_model.sync_send(8'h96);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h96);
    wr(`OFS_CFG, 32'h07);
    u_remote_line_model.send(9'h011, 9, 1'b1);
    u_remote_line_model.send(9'h022, 9, 1'b1);
    u_remote_line_model.send(9'h033, 9, 1'b1);
    u_remote_line_model.send(9'h044, 9, 1'b1);
    wait_set(`OFS_SCRA, 32'h80);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h11);
    rchk(`OFS_DATA, 32'hFFFFFFFF, 32'h22);
    rchk(`OFS_SCRA, 32'h88, 32'h88);
    wr(`OFS_SCRB, 32'h00);
    rchk(`OFS_SCRA, 32'h80, 32'h0);
    $display("test rx done");
  endtask : t_rx
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Reset, register defaults, then each scenario in turn
  initial begin
    rst_b = 1'b0;
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    tx_done_irq_taken = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rchk(`OFS_SCRA, 32'hFFFFFFFF, 32'h20);
    rchk(8'h1C, 32'hFFFFFFFF, 32'h0);
    rchk(`OFS_CFG, 32'hFFFFFFFF, 32'h03);
    wr(`OFS_BAUD, 32'h0);
    $display("test reset done");
    t_tx();
    t_par();
    t_rx();
    report_and_stop();
  end
endmodule : usart_tx_rx_buffer_flags_tb_top
`default_nettype wire
